/* verilog/phy_special_pkg.sv */
`default_nettype none
// ---------------------------------------------------------------------------
// Shared constants for the special control and indication register
// ---------------------------------------------------------------------------
package phy_special_pkg;

    // Register geometry
    localparam int          NUM_PORTS   = 2;
    localparam int          REG_WIDTH   = 16;
    localparam int          INDEX_WIDTH = 5;
    localparam logic [4:0]  REG_INDEX   = 5'h1B;

    // Field positions
    localparam int BIT_SRC_SEL  = 15;
    localparam int BIT_AUTO_EN  = 14;
    localparam int BIT_MAN_ST   = 13;
    localparam int BIT_HB_DIS   = 11;
    localparam int BIT_FAR_END_FAULT_ENABLE  = 5;
    localparam int BIT_RX_POL   = 4;

    // Writable and readable bit masks
    localparam logic [15:0] WRITE_MASK  = 16'hE820;
    localparam logic [15:0] READ_MASK   = 16'hE830;

    // Reset values of the stored bits
    localparam logic        SRC_SEL_RST = 1'b0;
    localparam logic        AUTO_EN_RST = 1'b0;
    localparam logic        MAN_ST_RST  = 1'b0;
    localparam logic        HB_DIS_RST  = 1'b0;
    localparam logic        FEFI_RST    = 1'b0;
    localparam logic        RX_POL_RST  = 1'b0;

    // Crossover modes, Gray ordered
    typedef enum logic [1:0] {
        MODE_MDI  = 2'b00,
        MODE_MDIX = 2'b01,
        MODE_AUTO = 2'b11
    } xover_mode_t;

    // Start-up sequence: capture straps once, then run
    typedef enum logic {
        ST_INIT = 1'b0,
        ST_RUN  = 1'b1
    } init_state_t;

    // Register-driven mode; the reserved pair keeps the previous mode
    function automatic xover_mode_t reg_mode(input logic        en,
                                             input logic        st,
                                             input xover_mode_t prev);
        xover_mode_t m;
        m = prev;
        unique case ({en, st})
            2'b00: m = MODE_MDI;
            2'b01: m = MODE_MDIX;
            2'b10: m = MODE_AUTO;
            2'b11: m = prev;
        endcase
        return m;
    endfunction

    // Strap-driven mode; automatic strap overrides the manual one
    function automatic xover_mode_t strap_mode(input logic auto_s,
                                               input logic man_s);
        xover_mode_t m;
        m = MODE_MDI;
        if (auto_s) begin
            m = MODE_AUTO;
        end else if (man_s) begin
            m = MODE_MDIX;
        end
        return m;
    endfunction

endpackage
`default_nettype wire

/* verilog/phy_port_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------------------
// One port copy of the special control and indication register
// ---------------------------------------------------------------------------
module phy_port_ctrl (
    input  wire logic                               clk_i,
    input  wire logic                               reset_n_i,
    input  wire logic                               wr_en_i,
    input  wire logic [phy_special_pkg::REG_WIDTH-1:0] wdata_i,
    input  wire logic                               soft_reset_i,
    input  wire logic                               strap_auto_i,
    input  wire logic                               strap_manual_i,
    input  wire logic                               fx_mode_i,
    input  wire logic                               rx_pol_rev_i,
    output logic [phy_special_pkg::REG_WIDTH-1:0]   value_o,
    output phy_special_pkg::xover_mode_t            mode_o,
    output logic                                    heartbeat_on_o,
    output logic                                    far_end_fault_enable_o,
    output logic                                    auto_strap_o,
    output logic                                    ready_o
);
    import phy_special_pkg::*;

    init_state_t state_reg,     state_next;
    logic        src_sel_reg,   src_sel_next;
    logic        auto_en_reg,   auto_en_next;
    logic        man_st_reg,    man_st_next;
    logic        hb_dis_reg,    hb_dis_next;
    logic        fefi_reg,      fefi_next;
    logic        rx_pol_reg,    rx_pol_next;
    logic        s_auto_reg,    s_auto_next;
    logic        s_man_reg,     s_man_next;
    logic        fx_reg,        fx_next;
    xover_mode_t mode_reg,      mode_next;
    logic        hb_on_reg,     hb_on_next;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Straps are caught in the first cycle after reset release, since an
    // asynchronous reset may only load constants.
    always_comb begin
        state_next   = state_reg;
        src_sel_next = src_sel_reg;
        auto_en_next = auto_en_reg;
        man_st_next  = man_st_reg;
        hb_dis_next  = hb_dis_reg;
        fefi_next    = fefi_reg;
        s_auto_next  = s_auto_reg;
        s_man_next   = s_man_reg;
        fx_next      = fx_reg;
        unique case (state_reg)
            ST_INIT: begin
                state_next  = ST_RUN;
                s_auto_next = strap_auto_i;      // RQ6
                s_man_next  = strap_manual_i;    // RQ3
                fx_next     = fx_mode_i;
                fefi_next   = fx_mode_i;         // RQ10
            end
            ST_RUN: begin
                if (wr_en_i) begin
                    src_sel_next = wdata_i[BIT_SRC_SEL];
                    auto_en_next = wdata_i[BIT_AUTO_EN];  // RQ4
                    man_st_next  = wdata_i[BIT_MAN_ST];
                    hb_dis_next  = wdata_i[BIT_HB_DIS];   // RQ8
                    fefi_next    = wdata_i[BIT_FAR_END_FAULT_ENABLE];  // RQ9
                end
                // Soft reset reloads bits 15 and 5 only
                if (soft_reset_i) begin
                    src_sel_next = SRC_SEL_RST;  // RQ12
                    fefi_next    = fx_reg;       // RQ10
                end
            end
        endcase
        rx_pol_next = rx_pol_rev_i;              // RQ11
        hb_on_next  = ~hb_dis_next;              // RQ8
        // Mode follows the same edge as the write that changes it
        if (src_sel_next) begin
            mode_next = reg_mode(auto_en_next, man_st_next,
                                 mode_reg);      // RQ2 RQ4
        end else begin
            mode_next = strap_mode(s_auto_next, s_man_next); // RQ3 RQ5
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg   <= ST_INIT;
            src_sel_reg <= SRC_SEL_RST;
            auto_en_reg <= AUTO_EN_RST;          // RQ12
            man_st_reg  <= MAN_ST_RST;
            hb_dis_reg  <= HB_DIS_RST;
            fefi_reg    <= FEFI_RST;
            rx_pol_reg  <= RX_POL_RST;
            s_auto_reg  <= 1'b0;
            s_man_reg   <= 1'b0;
            fx_reg      <= 1'b0;
            mode_reg    <= MODE_MDI;
            hb_on_reg   <= 1'b1;
        end else begin
            state_reg   <= state_next;
            src_sel_reg <= src_sel_next;
            auto_en_reg <= auto_en_next;
            man_st_reg  <= man_st_next;
            hb_dis_reg  <= hb_dis_next;
            fefi_reg    <= fefi_next;
            rx_pol_reg  <= rx_pol_next;
            s_auto_reg  <= s_auto_next;
            s_man_reg   <= s_man_next;
            fx_reg      <= fx_next;
            mode_reg    <= mode_next;
            hb_on_reg   <= hb_on_next;
        end
    end

    // Register image; reserved positions stay zero
    always_comb begin
        value_o              = '0;               // RQ13
        value_o[BIT_SRC_SEL] = src_sel_reg;
        value_o[BIT_AUTO_EN] = auto_en_reg;
        value_o[BIT_MAN_ST]  = man_st_reg;
        value_o[BIT_HB_DIS]  = hb_dis_reg;
        value_o[BIT_FAR_END_FAULT_ENABLE] = fefi_reg;
        value_o[BIT_RX_POL]  = rx_pol_reg;
    end

    assign mode_o         = mode_reg;
    assign heartbeat_on_o = hb_on_reg;
    assign far_end_fault_enable_o      = fefi_reg;
    assign auto_strap_o   = s_auto_reg;
    assign ready_o        = state_reg;

endmodule
`default_nettype wire

/* verilog/phy_special_ctrl_status_reg.sv */
`timescale 1ns/10ps
`default_nettype none
// How it works
// (RQ1) Register lives at index 27, 16 bits, one copy per PHY port.
// (RQ2) Source select set: crossover mode comes from the two register bits.
// (RQ3) Source select clear, the reset value: mode comes from sampled straps.
// (RQ4) Bits 00 no crossover, 01 crossover, 10 automatic; 11 never written.
// (RQ5) Auto strap high means automatic; else manual strap picks crossover.
// (RQ6) Sampled automatic strap of each port is visible as a status bit.
// (RQ7) Software should not pick automatic crossover on a fibre port.
// (RQ8) Heartbeat disable bit: 0 keeps the SQE test, 1 stops it.
// (RQ9) Far-end fault enable turns fault generation and detection on.
// (RQ10) Far-end fault enable resets to 1 on fibre ports, else 0.
// (RQ11) Receive polarity bit is read-only; 1 means reversed, resets to 0.
// (RQ12) Bits 14, 13, 11 clear on full reset, survive a soft reset.
// (RQ13) Reserved bits read zero and ignore writes.
module phy_special_ctrl_status_reg (
    input  wire logic                                  clk_i,
    input  wire logic                                  reset_n_i,
    input  wire logic                                  phy_sel_i,
    input  wire logic [phy_special_pkg::INDEX_WIDTH-1:0] reg_index_i,
    input  wire logic [phy_special_pkg::REG_WIDTH-1:0] wr_data_i,
    input  wire logic                                  wr_i,
    input  wire logic                                  rd_i,
    input  wire logic [phy_special_pkg::NUM_PORTS-1:0] soft_reset_i,
    input  wire logic [phy_special_pkg::NUM_PORTS-1:0] strap_auto_i,
    input  wire logic [phy_special_pkg::NUM_PORTS-1:0] strap_manual_i,
    input  wire logic [phy_special_pkg::NUM_PORTS-1:0] fx_mode_i,
    input  wire logic [phy_special_pkg::NUM_PORTS-1:0] rx_pol_rev_i,
    output logic [phy_special_pkg::REG_WIDTH-1:0]      rd_data_o,
    output logic [phy_special_pkg::NUM_PORTS-1:0][1:0] crossover_mode_o,
    output logic [phy_special_pkg::NUM_PORTS-1:0]      heartbeat_on_o,
    output logic [phy_special_pkg::NUM_PORTS-1:0]      far_end_fault_en_o,
    output logic [phy_special_pkg::NUM_PORTS-1:0]      auto_strap_state_o,
    output logic [phy_special_pkg::NUM_PORTS-1:0]      ready_o
);
    import phy_special_pkg::*;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Shared by the write and read paths
    function automatic logic addr_hit(input logic       sel,
                                      input logic [4:0] idx,
                                      input int         port);
        return (sel == port[0]) && (idx == REG_INDEX);  // RQ1
    endfunction

    logic [NUM_PORTS-1:0]                wr_port;
    logic [NUM_PORTS-1:0][REG_WIDTH-1:0] port_value;
    xover_mode_t [NUM_PORTS-1:0]         port_mode;
    logic [REG_WIDTH-1:0]                rd_data_reg, rd_data_next;

    // ------------------------------------------------------------------
    // Port copies
    // ------------------------------------------------------------------
    // Only the writable lanes reach a port copy
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            assign wr_port[p] = wr_i &&
                                addr_hit(phy_sel_i, reg_index_i, p); // RQ1
            assign crossover_mode_o[p] = port_mode[p];
            phy_port_ctrl u_port (
                .clk_i          (clk_i),
                .reset_n_i      (reset_n_i),
                .wr_en_i        (wr_port[p]),
                .wdata_i        (wr_data_i & WRITE_MASK),   // RQ13
                .soft_reset_i   (soft_reset_i[p]),
                .strap_auto_i   (strap_auto_i[p]),
                .strap_manual_i (strap_manual_i[p]),
                .fx_mode_i      (fx_mode_i[p]),
                .rx_pol_rev_i   (rx_pol_rev_i[p]),
                .value_o        (port_value[p]),
                .mode_o         (port_mode[p]),
                .heartbeat_on_o (heartbeat_on_o[p]),
                .far_end_fault_enable_o      (far_end_fault_en_o[p]),
                .auto_strap_o   (auto_strap_state_o[p]),
                .ready_o        (ready_o[p])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Data stand one cycle after the strobe and are zero otherwise, so an
    // unmapped index or idle bus simply reads as zero.
    always_comb begin
        rd_data_next = '0;
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (rd_i && addr_hit(phy_sel_i, reg_index_i, i)) begin
                rd_data_next = port_value[i] & READ_MASK;  // RQ13
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_reg <= '0;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    assign rd_data_o = rd_data_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    chk_read_idle_zero: assert property ( // RQ1
        !$past(rd_i) |-> rd_data_o == '0)
        else $error("read data present without a read strobe");

    chk_reserved_zero: assert property ( // RQ13
        (rd_data_o & ~READ_MASK) == '0)
        else $error("reserved bit read as one");

    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_chk
            chk_write_index: assert property ( // RQ1
                ready_o[p] && wr_port[p] && !soft_reset_i[p] |=>
                (port_value[p] & WRITE_MASK) ==
                ($past(wr_data_i) & WRITE_MASK))
                else $error("write to the register did not store");

            chk_other_index: assert property ( // RQ1
                ready_o[p] && wr_i && reg_index_i != REG_INDEX &&
                !soft_reset_i[p] |=>
                $stable(port_value[p] & WRITE_MASK))
                else $error("write to another index changed the register");

            chk_reg_source: assert property ( // RQ2
                port_value[p][BIT_SRC_SEL] &&
                !(port_value[p][BIT_AUTO_EN] && port_value[p][BIT_MAN_ST])
                |-> port_mode[p] == (port_value[p][BIT_AUTO_EN] ? MODE_AUTO
                                    : port_value[p][BIT_MAN_ST] ? MODE_MDIX
                                    : MODE_MDI))
                else $error("register bits do not set crossover mode");

            chk_reserved_hold: assert property ( // RQ4
                ready_o[p] && wr_port[p] && !soft_reset_i[p] &&
                (wr_data_i[15:13] == 3'b111) |=>
                $stable(port_mode[p]))
                else $error("reserved pair changed the crossover mode");

            chk_strap_auto: assert property ( // RQ3
                ready_o[p] && !port_value[p][BIT_SRC_SEL] &&
                auto_strap_state_o[p] |-> port_mode[p] == MODE_AUTO)
                else $error("automatic strap not followed");

            // Manual strap must pick the mode, not merely avoid automatic
            chk_strap_manual: assert property ( // RQ5
                ready_o[p] && !port_value[p][BIT_SRC_SEL] &&
                !auto_strap_state_o[p] |-> port_mode[p] != MODE_AUTO &&
                (!$rose(ready_o[p]) || port_mode[p] ==
                 ($past(strap_manual_i[p]) ? MODE_MDIX : MODE_MDI)))
                else $error("manual strap gave the wrong mode");

            chk_strap_status: assert property ( // RQ6
                $rose(ready_o[p]) |->
                auto_strap_state_o[p] == $past(strap_auto_i[p]))
                else $error("strap status bit not sampled");

            chk_heartbeat: assert property ( // RQ8
                heartbeat_on_o[p] == !port_value[p][BIT_HB_DIS])
                else $error("heartbeat enable disagrees with its bit");

            // Output must also take a plain write of its bit
            chk_fefi_out: assert property ( // RQ9
                far_end_fault_en_o[p] == port_value[p][BIT_FAR_END_FAULT_ENABLE] &&
                (!$past(ready_o[p] && wr_port[p] && !soft_reset_i[p]) ||
                 far_end_fault_en_o[p] == $past(wr_data_i[BIT_FAR_END_FAULT_ENABLE])))
                else $error("far-end fault enable disagrees with its bit");

            chk_fefi_default: assert property ( // RQ10
                $rose(ready_o[p]) |->
                port_value[p][BIT_FAR_END_FAULT_ENABLE] == $past(fx_mode_i[p]))
                else $error("far-end fault default wrong at start");

            chk_rx_polarity: assert property ( // RQ11
                ##1 port_value[p][BIT_RX_POL] == $past(rx_pol_rev_i[p]))
                else $error("polarity bit not following the detector");

            chk_soft_keep: assert property ( // RQ12
                ready_o[p] && soft_reset_i[p] && !wr_port[p] |=>
                $stable(port_value[p][14:13]) &&
                $stable(port_value[p][BIT_HB_DIS]) &&
                !port_value[p][BIT_SRC_SEL])
                else $error("soft reset disturbed the kept bits");

            cov_auto_reg: cover property (
                wr_port[p] && wr_data_i[15:13] == 3'b110 ##1
                port_mode[p] == MODE_AUTO);

            cov_manual_x: cover property (
                wr_port[p] && wr_data_i[15:13] == 3'b101 ##1
                port_mode[p] == MODE_MDIX);

            cov_soft_rst: cover property (
                port_value[p][BIT_HB_DIS] && soft_reset_i[p] ##1
                port_value[p][BIT_HB_DIS]);
        end
    endgenerate

    cov_read_back: cover property (
        rd_i && reg_index_i == REG_INDEX ##1 rd_data_o != '0);

endmodule
`default_nettype wire

/* tb/tb_phy_special_ctrl_status_reg.sv */
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------------------
// Bench for the special control and indication register, both port copies
// ---------------------------------------------------------------------------
module tb_phy_special_ctrl_status_reg;
    import phy_special_pkg::*;

    logic                          clk_i;
    logic                          reset_n_i;
    logic                          phy_sel_i;
    logic [INDEX_WIDTH-1:0]        reg_index_i;
    logic [REG_WIDTH-1:0]          wr_data_i;
    logic                          wr_i;
    logic                          rd_i;
    logic [NUM_PORTS-1:0]          soft_reset_i;
    logic [NUM_PORTS-1:0]          strap_auto_i;
    logic [NUM_PORTS-1:0]          strap_manual_i;
    logic [NUM_PORTS-1:0]          fx_mode_i;
    logic [NUM_PORTS-1:0]          rx_pol_rev_i;
    logic [REG_WIDTH-1:0]          rd_data_o;
    logic [NUM_PORTS-1:0][1:0]     crossover_mode_o;
    logic [NUM_PORTS-1:0]          heartbeat_on_o;
    logic [NUM_PORTS-1:0]          far_end_fault_en_o;
    logic [NUM_PORTS-1:0]          auto_strap_state_o;
    logic [NUM_PORTS-1:0]          ready_o;
    int                            fail_count;
    int                            cmp_count;
    int                            cycles;
    logic [REG_WIDTH-1:0]          rdat;

    phy_special_ctrl_status_reg phy_special_ctrl_status_reg_inst (
        .clk_i              (clk_i),
        .reset_n_i          (reset_n_i),
        .phy_sel_i          (phy_sel_i),
        .reg_index_i        (reg_index_i),
        .wr_data_i          (wr_data_i),
        .wr_i               (wr_i),
        .rd_i               (rd_i),
        .soft_reset_i       (soft_reset_i),
        .strap_auto_i       (strap_auto_i),
        .strap_manual_i     (strap_manual_i),
        .fx_mode_i          (fx_mode_i),
        .rx_pol_rev_i       (rx_pol_rev_i),
        .rd_data_o          (rd_data_o),
        .crossover_mode_o   (crossover_mode_o),
        .heartbeat_on_o     (heartbeat_on_o),
        .far_end_fault_en_o (far_end_fault_en_o),
        .auto_strap_state_o (auto_strap_state_o),
        .ready_o            (ready_o)
    );

    // ------------------------------------------------------------------
    // Clock, hang guard and closing report
    // ------------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Whole run is about a hundred cycles; generous ceiling
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: %s got %h expected %h",
                     $time, what, got, exp);
        end
    endtask

    // ------------------------------------------------------------------
    // Register bus tasks: one-cycle strobes, read data one cycle later
    // ------------------------------------------------------------------
    task automatic reg_write(input logic sel, input logic [4:0] idx,
                             input logic [15:0] data);
        @(posedge clk_i);
        phy_sel_i   <= sel;
        reg_index_i <= idx;
        wr_data_i   <= data;
        wr_i        <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask

    task automatic reg_read(input logic sel, input logic [4:0] idx,
                            output logic [15:0] data);
        @(posedge clk_i);
        phy_sel_i   <= sel;
        reg_index_i <= idx;
        rd_i        <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        data = rd_data_o;
    endtask

    // Full reset with a strap set; bounded wait for strap capture
    task automatic do_reset(input logic [1:0] sa, input logic [1:0] sm,
                            input logic [1:0] fx);
        int n;
        @(posedge clk_i);
        reset_n_i      <= 1'b0;
        strap_auto_i   <= sa;
        strap_manual_i <= sm;
        fx_mode_i      <= fx;
        repeat (16) @(posedge clk_i);
        reset_n_i <= 1'b1;
        for (n = 0; n < 20 && ready_o !== 2'b11; n++) begin
            @(posedge clk_i);
        end
        #1;
        check(16'(ready_o), 16'h0003, "ready");
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [1:0]  sa_t [2];
        logic [1:0]  sm_t [2];
        logic [1:0]  fx_t [2];
        logic [15:0] wv [3];
        xover_mode_t em [3];
        xover_mode_t exp_m;
        sa_t = '{2'b10, 2'b10};
        sm_t = '{2'b10, 2'b01};
        fx_t = '{2'b10, 2'b01};
        wv = '{16'h8000, 16'hA000, 16'hC000};
        em = '{MODE_MDI, MODE_MDIX, MODE_AUTO};
        fail_count = 0;
        cmp_count = 0;
        reset_n_i = 1'b0;
        phy_sel_i = 1'b0;
        reg_index_i = '0;
        wr_data_i = '0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        soft_reset_i = '0;
        strap_auto_i = '0;
        strap_manual_i = '0;
        fx_mode_i = '0;
        rx_pol_rev_i = '0;
        // Two strap sets cover all four strap combinations
        for (int s = 0; s < 2; s++) begin
            do_reset(sa_t[s], sm_t[s], fx_t[s]);
            for (int p = 0; p < 2; p++) begin
                exp_m = sa_t[s][p] ? MODE_AUTO
                      : (sm_t[s][p] ? MODE_MDIX : MODE_MDI);
                check(16'(crossover_mode_o[p]), 16'(exp_m), "mode");
                check(16'(auto_strap_state_o[p]),
                      16'(sa_t[s][p]), "strap");
                check(16'(far_end_fault_en_o[p]),
                      16'(fx_t[s][p]), "fefi");
                check(16'(heartbeat_on_o[p]), 16'h0001, "heartbeat");
                reg_read(p[0], REG_INDEX, rdat);
                check(rdat, {10'h0, fx_t[s][p], 5'h0}, "reset value");
            end
        end
        // Register modes on the copper port only; port 0 is fibre
        for (int i = 0; i < 3; i++) begin
            reg_write(1'b1, REG_INDEX, wv[i]);
            check(16'(crossover_mode_o[1]), 16'(em[i]), "reg mode");
            check(16'(crossover_mode_o[0]), 16'(MODE_MDIX), "other");
        end
        // Reserved pair keeps the previous mode
        reg_write(1'b1, REG_INDEX, 16'hE000);
        check(16'(crossover_mode_o[1]), 16'(MODE_AUTO), "reserved");
        reg_write(1'b1, REG_INDEX, 16'hFFFF);
        check(16'(heartbeat_on_o[1]), 16'h0000, "heartbeat off");
        check(16'(far_end_fault_en_o[1]), 16'h0001, "fefi on");
        reg_read(1'b1, REG_INDEX, rdat);
        check(rdat, 16'hE820, "reserved bits");
        // Unmapped index neither stores nor answers
        reg_write(1'b1, 5'h1A, 16'h0000);
        reg_read(1'b1, 5'h1A, rdat);
        check(rdat, 16'h0000, "unmapped read");
        reg_read(1'b1, REG_INDEX, rdat);
        check(rdat, 16'hE820, "unmapped write");
        // Source select: register overrides straps, then hands back
        reg_write(1'b0, REG_INDEX, 16'h8000);
        check(16'(crossover_mode_o[0]), 16'(MODE_MDI), "override");
        reg_write(1'b0, REG_INDEX, 16'h0000);
        check(16'(crossover_mode_o[0]), 16'(MODE_MDIX), "strap back");
        check(16'(far_end_fault_en_o[0]), 16'h0000, "fefi off");
        // Polarity bit follows the detector and ignores writes
        @(posedge clk_i);
        rx_pol_rev_i <= 2'b10;
        reg_write(1'b1, REG_INDEX, 16'h0000);
        reg_read(1'b1, REG_INDEX, rdat);
        check(rdat, 16'h0010, "polarity");
        @(posedge clk_i);
        rx_pol_rev_i <= 2'b00;
        reg_write(1'b1, REG_INDEX, 16'h0010);
        reg_read(1'b1, REG_INDEX, rdat);
        check(rdat, 16'h0000, "polarity ro");
        // Soft reset keeps 14, 13, 11; source and fefi fall back
        reg_write(1'b0, REG_INDEX, 16'hC800);
        @(posedge clk_i);
        soft_reset_i <= 2'b01;
        @(posedge clk_i);
        soft_reset_i <= 2'b00;
        #1;
        reg_read(1'b0, REG_INDEX, rdat);
        check(rdat, 16'h4820, "soft reset");
        check(16'(heartbeat_on_o[0]), 16'h0000, "soft heartbeat");
        check(16'(crossover_mode_o[0]), 16'(MODE_MDIX), "soft mode");
        // Strap changes after start are ignored
        @(posedge clk_i);
        strap_auto_i <= 2'b01;
        repeat (3) @(posedge clk_i);
        #1;
        check(16'(auto_strap_state_o), 16'h0002, "strap held");
        // Full reset clears the kept bits
        do_reset(sa_t[1], sm_t[1], fx_t[1]);
        reg_read(1'b0, REG_INDEX, rdat);
        check(rdat, 16'h0020, "full reset");
        test_done();
    end
endmodule
`default_nettype wire
